//--- lfw_pkg.sv
// Package for the segment display frame and waveform driver.
// Assumes one 20 MHz clock and an AXI4-Lite register port.
package lfw_pkg;

   // ***************************************************************
   // Register map (byte addresses)
   // ***************************************************************
   localparam logic [7:0] OFS_CONTROL   = 8'h00;
   localparam logic [7:0] OFS_PRESCALE  = 8'h04;
   localparam logic [7:0] OFS_STATUS    = 8'h08;
   localparam logic [7:0] OFS_PIXEL0    = 8'h10;
   localparam logic [7:0] OFS_PIXEL_END = 8'h3c;
   localparam int         NUM_PIXEL_REG = 12;
   localparam int         NUM_COMMON    = 4;
   localparam int         NUM_SEGMENT   = 24;
   localparam int         REG_PER_ROW   = 3;

   // ***************************************************************
   // Control and status register fields
   // ***************************************************************
   localparam int BIT_ENABLE   = 7;
   localparam int BIT_SLEEPSEL = 6;
   localparam int BIT_WRERR    = 5;
   localparam int BIT_WAVE     = 4;
   localparam int POS_SOURCE   = 2;
   localparam int POS_COMMONS  = 0;
   localparam int BIT_ACTIVE   = 0;
   localparam int BIT_DISP_IRQ = 1;
   localparam int BIT_FRM_IRQ  = 2;
   localparam logic [7:0] CONTROL_RESET  = 8'h00;
   localparam logic [3:0] PRESCALE_RESET = 4'h0;

   // Clock source and common count codes
   localparam logic [1:0] SRC_SYS_DIV   = 2'h0;
   localparam logic [1:0] SRC_CRYSTAL   = 2'h1;
   localparam logic [1:0] SRC_LOW_FREQ  = 2'h2;
   localparam logic [1:0] COMMONS_STATIC = 2'h0;

   // ***************************************************************
   // Timing
   // ***************************************************************
   localparam int SYS_DIVIDE   = 256;
   localparam int BASE_DIVIDE  = 32;
   localparam int WRITE_WIN_US = 100;
   localparam int CLK_MHZ      = 20;
   localparam int WRITE_WIN_CYC = WRITE_WIN_US * CLK_MHZ;
   localparam logic [31:0] SLVERR = 32'h0;

   // Bus response codes
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b001,
      ST_RUN  = 3'b010,
      ST_STOP = 3'b100
   } lfw_state_e;

   typedef struct packed
   {
      logic [3:0]  common;
      logic [23:0] segment;
   } lfw_drive_s;

endpackage

//--- lfw_driver.sv
// Segment display frame timer, waveform generator and register slave.
// Assumes low-speed clock ticks and a sleep request synchronous to aclk.
//
// Overview of operation
// - Static frame: source over 4x1xPx32
// - Half multiplex: source over 2x2xPx32
// - Third/quarter: source over 1xNxPx32
// - Three selectable frame clock sources
// - Pixel bit at reg 3k+n/8, bit n%8
// - Zero net DC across each pixel
// - Dark or clear: two RMS levels only
// - Type A inverts per slice, B per frame
// - Divided system source halts on sleep
// - Interrupt when active flag falls
// - First common edge starts a frame
// - Frame interrupt after last data fetch
// - Type B interrupts only at phase ends
// - Locked write dropped, error flag set
// - No frame interrupt in A or static
// - Common count codes 00 to 11
// - Wave bit: zero A, one B
// - Disable finishes frame, or frame pair in B, then clears active
// - One bit per common-segment pixel
//
// The register offsets and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps

module lfw_driver
(
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic         crystal_tick,
   input  wire logic         low_freq_tick,
   input  wire logic         sleep_req,
   input  wire logic [7:0]   awaddr,
   input  wire logic         awvalid,
   output logic              awready,
   input  wire logic [31:0]  wdata,
   input  wire logic [3:0]   wstrb,
   input  wire logic         wvalid,
   output logic              wready,
   output logic [1:0]        bresp,
   output logic              bvalid,
   input  wire logic         bready,
   input  wire logic [7:0]   araddr,
   input  wire logic         arvalid,
   output logic              arready,
   output logic [31:0]       rdata,
   output logic [1:0]        rresp,
   output logic              rvalid,
   input  wire logic         rready,
   output lfw_pkg::lfw_drive_s drive_level,
   output lfw_pkg::lfw_drive_s drive_phase,
   output logic              display_active_flag,
   output logic              frame_irq,
   output logic              display_irq
);

   // ***************************************************************
   // State
   // ***************************************************************
   typedef struct packed
   {
      lfw_pkg::lfw_state_e  st;
      logic [7:0]           ctrl;
      logic [3:0]           prescale;
      logic [95:0]          pixel_bits;
      logic [7:0]           sysdiv;
      logic [3:0]           pre_cnt;
      logic [4:0]           base_cnt;
      logic [1:0]           slot;
      logic [1:0]           sub;
      logic                 frame_odd;
      logic                 frm_flag;
      logic                 disp_flag;
      logic [15:0]          win_cnt;
      logic                 aw_got;
      logic [7:0]           aw_addr;
      logic                 w_got;
      logic [31:0]          w_data;
      logic [3:0]           w_strb;
      logic                 bv;
      logic [1:0]           br;
      logic                 rv;
      logic [31:0]          rd;
      logic [1:0]           rr;
      lfw_pkg::lfw_drive_s  lvl;
      lfw_pkg::lfw_drive_s  phs;
   } lfw_regs_s;

   lfw_regs_s q;
   lfw_regs_s d;

   // Pixel lookup: common k, segment n
   function automatic logic pixel_of(input logic [95:0] pix, input logic [1:0] k,
                                     input logic [4:0] n);
      logic [6:0] idx;
      idx = 7'(({5'h0, k} * 7'(lfw_pkg::REG_PER_ROW) + 7'(n >> 3)) * 7'd8 + 7'(n[2:0]));
      return pix[idx];
   endfunction

   // Byte address to pixel register index
   function automatic logic [3:0] pix_index(input logic [7:0] a);
      logic [7:0] off;
      off = a - lfw_pkg::OFS_PIXEL0;
      return off[5:2];
   endfunction

   logic [1:0] commons;
   logic       wave_b;
   logic [1:0] src;
   logic       tick;
   logic       slot_end;
   logic       base_end;
   logic       frame_end;
   logic       write_locked;
   logic       do_write;
   logic [2:0] sub_max;
   logic [7:0] wbyte;
   logic       phase_now;

   // Field decode
   always_comb
   begin
      commons = q.ctrl[lfw_pkg::POS_COMMONS +: 2];
      wave_b  = q.ctrl[lfw_pkg::BIT_WAVE];
      src     = q.ctrl[lfw_pkg::POS_SOURCE +: 2];
   end

   // Source selection and divider chain
   always_comb
   begin
      unique case (src)
         lfw_pkg::SRC_SYS_DIV:  tick = (q.sysdiv == 8'hff);
         lfw_pkg::SRC_CRYSTAL:  tick = crystal_tick;
         lfw_pkg::SRC_LOW_FREQ: tick = low_freq_tick;
         default:               tick = 1'b0;
      endcase
      if (sleep_req && (src == lfw_pkg::SRC_SYS_DIV || q.ctrl[lfw_pkg::BIT_SLEEPSEL]))
         tick = 1'b0;
      // slot phases 4, 2 or 1
      unique case (commons)
         2'h0:    sub_max = 3'd3;
         2'h1:    sub_max = 3'd1;
         default: sub_max = 3'd0;
      endcase
      base_end  = tick && (q.pre_cnt == q.prescale) &&
                  (q.base_cnt == 5'(lfw_pkg::BASE_DIVIDE - 1));
      slot_end  = base_end && ({1'b0, q.sub} == sub_max);
      frame_end = slot_end && (q.slot == commons);
      // one sub-phase per slot flips at half slot
      phase_now = wave_b ? q.frame_odd : ((sub_max == 3'd0) ? q.base_cnt[4] : q.sub[0]);
   end

   // Lock applies to Type B multiplexed only, outside window
   always_comb
   begin
      write_locked = wave_b && (commons != lfw_pkg::COMMONS_STATIC) &&
                     (q.st == lfw_pkg::ST_RUN) && (q.win_cnt == 16'h0);
   end

   // Next state
   always_comb
   begin
      d = q;
      do_write = q.aw_got && q.w_got && !q.bv;
      wbyte = q.w_data[7:0];
      d.sysdiv = q.sysdiv + 8'h01;
      if (q.win_cnt != 16'h0)
         d.win_cnt = q.win_cnt - 16'h0001;

      // Divider counters after the system divider only run while active
      if (q.st != lfw_pkg::ST_IDLE && tick)
      begin
         d.pre_cnt = (q.pre_cnt == q.prescale) ? 4'h0 : q.pre_cnt + 4'h1;
         if (q.pre_cnt == q.prescale)
            d.base_cnt = q.base_cnt + 5'h01;
         if (base_end)
            d.sub = ({1'b0, q.sub} == sub_max) ? 2'h0 : q.sub + 2'h1;
         if (slot_end)
            d.slot = (q.slot >= commons) ? 2'h0 : q.slot + 2'h1;
      end

      // Frame sequencer
      unique case (q.st)
         lfw_pkg::ST_IDLE:
         begin
            if (q.ctrl[lfw_pkg::BIT_ENABLE])
            begin
               d.st = lfw_pkg::ST_RUN;
               d.pre_cnt = 4'h0;
               d.base_cnt = 5'h0;
               d.sub = 2'h0;
               d.slot = 2'h0;
               d.frame_odd = 1'b0;
            end
         end
         lfw_pkg::ST_RUN:
         begin
            if (frame_end)
            begin
               d.frame_odd = !q.frame_odd;
               if (wave_b && commons != lfw_pkg::COMMONS_STATIC && q.frame_odd)
               begin
                  d.frm_flag = 1'b1;
                  d.win_cnt = 16'(lfw_pkg::WRITE_WIN_CYC);
               end
               if (!q.ctrl[lfw_pkg::BIT_ENABLE] && (!wave_b || q.frame_odd))
                  d.st = lfw_pkg::ST_STOP;
            end
         end
         lfw_pkg::ST_STOP:
         begin
            d.st = lfw_pkg::ST_IDLE;
            d.disp_flag = 1'b1;
         end
      endcase

      // Drive generation, each common owns one slot
      for (int k = 0; k < lfw_pkg::NUM_COMMON; k++)
      begin
         // unused commons stay idle after a mode change
         d.lvl.common[k] = (q.st == lfw_pkg::ST_RUN) && (2'(k) == q.slot) &&
                           (2'(k) <= commons);
      end
      for (int n = 0; n < lfw_pkg::NUM_SEGMENT; n++)
      begin
         d.lvl.segment[n] = (q.st == lfw_pkg::ST_RUN) && pixel_of(q.pixel_bits, q.slot, 5'(n));
      end
      d.phs.common  = {lfw_pkg::NUM_COMMON{phase_now}};
      d.phs.segment = {lfw_pkg::NUM_SEGMENT{phase_now}};

      // Write channel capture
      if (awvalid && !q.aw_got)
      begin
         d.aw_got = 1'b1;
         d.aw_addr = awaddr;
      end
      if (wvalid && !q.w_got)
      begin
         d.w_got = 1'b1;
         d.w_data = wdata;
         d.w_strb = wstrb;
      end
      if (q.bv && bready)
         d.bv = 1'b0;

      // Register write
      if (do_write)
      begin
         d.aw_got = 1'b0;
         d.w_got = 1'b0;
         d.bv = 1'b1;
         d.br = lfw_pkg::RESP_OKAY;
         if (q.aw_addr == lfw_pkg::OFS_CONTROL && q.w_strb[0])
         begin
            // Error flag only clears by writing zero; writing one leaves it
            d.ctrl = {wbyte[7:6], q.ctrl[5] & wbyte[5], wbyte[4:0]};
         end
         else if (q.aw_addr == lfw_pkg::OFS_PRESCALE && q.w_strb[0])
            d.prescale = wbyte[3:0];
         else if (q.aw_addr == lfw_pkg::OFS_STATUS && q.w_strb[0])
         begin
            // Write one to clear; new event set later wins
            if (wbyte[lfw_pkg::BIT_DISP_IRQ])
               d.disp_flag = 1'b0;
            if (wbyte[lfw_pkg::BIT_FRM_IRQ])
               d.frm_flag = 1'b0;
         end
         else if (q.aw_addr >= lfw_pkg::OFS_PIXEL0 && q.aw_addr <= lfw_pkg::OFS_PIXEL_END &&
                  q.aw_addr[1:0] == 2'h0)
         begin
            if (write_locked || sleep_req)
               d.ctrl[lfw_pkg::BIT_WRERR] = 1'b1;
            else if (q.w_strb[0])
               d.pixel_bits[pix_index(q.aw_addr) * 8 +: 8] = wbyte;
         end
         else if (q.aw_addr[1:0] != 2'h0 || q.aw_addr > lfw_pkg::OFS_PIXEL_END ||
                  (q.aw_addr > lfw_pkg::OFS_STATUS && q.aw_addr < lfw_pkg::OFS_PIXEL0))
            d.br = lfw_pkg::RESP_SLVERR;
      end
      // Hardware set wins over software clear
      if (q.st == lfw_pkg::ST_STOP)
         d.disp_flag = 1'b1;
      if (q.st == lfw_pkg::ST_RUN && frame_end && wave_b &&
          commons != lfw_pkg::COMMONS_STATIC && q.frame_odd)
         d.frm_flag = 1'b1;

      // Read channel
      if (q.rv && rready)
         d.rv = 1'b0;
      if (arvalid && !q.rv)
      begin
         d.rv = 1'b1;
         d.rr = lfw_pkg::RESP_OKAY;
         d.rd = 32'h0;
         if (araddr == lfw_pkg::OFS_CONTROL)
            d.rd[7:0] = q.ctrl;
         else if (araddr == lfw_pkg::OFS_PRESCALE)
            d.rd[3:0] = q.prescale;
         else if (araddr == lfw_pkg::OFS_STATUS)
            d.rd[2:0] = {q.frm_flag, q.disp_flag, q.st != lfw_pkg::ST_IDLE};
         else if (araddr >= lfw_pkg::OFS_PIXEL0 && araddr <= lfw_pkg::OFS_PIXEL_END &&
                  araddr[1:0] == 2'h0)
            d.rd[7:0] = q.pixel_bits[pix_index(araddr) * 8 +: 8];
         else
            d.rr = lfw_pkg::RESP_SLVERR;
      end
   end

   // State register, synchronous reset
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         q <= '0;
         q.st <= lfw_pkg::ST_IDLE;
         q.ctrl <= lfw_pkg::CONTROL_RESET;
         q.prescale <= lfw_pkg::PRESCALE_RESET;
      end
      else
         q <= d;
   end

   // Outputs straight from flops
   always_comb
   begin
      awready = !q.aw_got;
      wready  = !q.w_got;
      bvalid  = q.bv;
      bresp   = q.br;
      arready = !q.rv;
      rvalid  = q.rv;
      rdata   = q.rd;
      rresp   = q.rr;
      drive_level = q.lvl;
      drive_phase = q.phs;
      display_active_flag = (q.st != lfw_pkg::ST_IDLE);
      frame_irq   = q.frm_flag;
      display_irq = q.disp_flag;
   end

   // ***************************************************************
   // Checks
   // ***************************************************************
   AST_STOP_FLAG: assert property (@(posedge aclk) disable iff (!aresetn)
      q.st == lfw_pkg::ST_STOP |=> q.disp_flag && !display_active_flag)
      else $error("display flag not set on shutdown");
   AST_STICKY: assert property (@(posedge aclk) disable iff (!aresetn)
      q.disp_flag && !(do_write && q.aw_addr == lfw_pkg::OFS_STATUS) |=> q.disp_flag)
      else $error("display flag dropped");
   AST_NO_A_IRQ: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(q.frm_flag) |-> $past(wave_b) && $past(commons) != 2'h0)
      else $error("frame flag in type A or static");
   AST_WRITE_ERROR_FLAG: assert property (@(posedge aclk) disable iff (!aresetn)
      do_write && write_locked && q.aw_addr == lfw_pkg::OFS_PIXEL0
      |=> q.ctrl[lfw_pkg::BIT_WRERR] && q.pixel_bits[7:0] == $past(q.pixel_bits[7:0]))
      else $error("locked write not refused");
   AST_WINDOW: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(q.frm_flag) |-> !write_locked)
      else $error("window closed at frame flag");
   AST_SLEEP: assert property (@(posedge aclk) disable iff (!aresetn)
      sleep_req && src == lfw_pkg::SRC_SYS_DIV
      |=> $stable({q.pre_cnt, q.base_cnt, q.sub, q.slot}))
      else $error("system source ran in sleep");
   AST_ONE_COM: assert property (@(posedge aclk) disable iff (!aresetn)
      $onehot0(q.lvl.common))
      else $error("two commons active");
   AST_FINISH: assert property (@(posedge aclk) disable iff (!aresetn)
      q.st == lfw_pkg::ST_RUN && !frame_end |=> q.st != lfw_pkg::ST_STOP)
      else $error("stopped mid frame");

endmodule // lfw_driver

//--- lfw_glass_model.sv
// Passive glass model: watches common drive and measures each frame.
// Assumes drive_level is registered on aclk by the driver.
`timescale 1ns/1ps

module lfw_glass_model
(
   input  wire logic                aclk,
   input  wire lfw_pkg::lfw_drive_s drive_level,
   output int                       frame_len,
   output int                       frame_cnt
);
   int   run_cnt = 0;
   logic com0_q  = 1'b0;

   // frame start at common 0 edge
   always @(posedge aclk)
   begin
      com0_q  <= drive_level.common[0];
      run_cnt <= run_cnt + 1;
      if (drive_level.common[0] === 1'b1 && com0_q === 1'b0)
      begin
         frame_len <= run_cnt + 1;
         run_cnt   <= 0;
         frame_cnt <= frame_cnt + 1;
      end
   end
endmodule // lfw_glass_model

//--- lfw_driver_tb.sv
// Self-checking bench for the segment display frame and waveform driver.
// Assumes the glass model beside it; the bench is the AXI4-Lite master.
`timescale 1ns/1ps

module lfw_driver_tb;
   // ************************************************************
   // Signals
   // ************************************************************
   localparam int         LIMIT = 60000;
   localparam logic [7:0] CTL   = lfw_pkg::OFS_CONTROL;
   localparam logic [7:0] PSC   = lfw_pkg::OFS_PRESCALE;
   localparam logic [7:0] STA   = lfw_pkg::OFS_STATUS;
   localparam logic [7:0] PIX   = lfw_pkg::OFS_PIXEL0;
   logic aclk = 1'b0, aresetn = 1'b0, crystal_tick = 1'b0, low_freq_tick = 1'b0;
   logic sleep_req = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hf;
   logic awready, wready, bvalid, arready, rvalid, display_active_flag, frame_irq, display_irq;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   lfw_pkg::lfw_drive_s drive_level, drive_phase;
   int err_total = 0, tests_run = 0, cyc = 0, frame_len, frame_cnt;

   lfw_driver uut (.aclk(aclk), .aresetn(aresetn), .crystal_tick(crystal_tick),
      .low_freq_tick(low_freq_tick), .sleep_req(sleep_req), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .drive_level(drive_level), .drive_phase(drive_phase),
      .display_active_flag(display_active_flag), .frame_irq(frame_irq),
      .display_irq(display_irq));
   lfw_glass_model panel (.aclk(aclk), .drive_level(drive_level), .frame_len(frame_len),
      .frame_cnt(frame_cnt));

   // ************************************************************
   // Clock, slow ticks and hang guard
   // ************************************************************
   always #25 aclk = ~aclk;

   // Crystal ticks every 2nd cycle, low source every 3rd, so sources differ
   always @(posedge aclk)
   begin
      cyc           <= cyc + 1;
      crystal_tick  <= (cyc % 2) == 0;
      low_freq_tick <= (cyc % 3) == 0;
      if (cyc == LIMIT)
      begin
         err_total++;
         print_verdict();
      end
   end

   // ************************************************************
   // Shared tasks
   // ************************************************************
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Write; an extra edge keeps two drives of bready out of one step
   task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      r = bresp;
      bready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      axw(a, d, r);
      chk(32'(r), 32'(lfw_pkg::RESP_OKAY));
   endtask

   task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      logic [1:0]  r;
      axr(a, d, r);
      chk(d, exp);
   endtask

   task automatic wt(ref logic s, input logic v, output int n);
      n = 0;
      while (s !== v && n < 20000)
      begin
         @(posedge aclk);
         n++;
      end
   endtask

   function automatic logic [7:0] pv(input int i);
      return 8'(i * 37 + 5);
   endfunction

   // Runs a mode for three frames; b asks for phase flip between frames
   task automatic meas(input logic [7:0] ctl, input logic [3:0] ps, input int exp, input bit b);
      int c0;
      int n = 0;
      bit got = 1'b0;
      logic [3:0] seen = 4'h0;
      logic [1:0] ph = 2'b00;
      lfw_pkg::lfw_drive_s p2;
      wr(PSC, 32'(ps));
      wr(CTL, 32'(ctl));
      c0 = frame_cnt;
      while (frame_cnt < c0 + 3 && n < 5000)
      begin
         @(posedge aclk);
         n++;
         seen = seen | drive_level.common;
         ph = ph | {drive_phase.common[0], ~drive_phase.common[0]};
         if (frame_cnt == c0 + 2 && !got) p2 = drive_phase;
         if (frame_cnt == c0 + 2) got = 1'b1;
      end
      chk(32'(frame_len), 32'(exp));
      chk(32'(seen), 32'((1 << (ctl[1:0] + 1)) - 1));
      chk(32'(ph), 32'h3);
      if (b) chk(32'(p2 !== drive_phase), 32'h1);
   endtask

   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_reg();
      logic [31:0] d;
      logic [1:0]  r;
      rdc(CTL, 32'h0);
      rdc(PSC, 32'h0);
      rdc(STA, 32'h0);
      axr(8'h40, d, r);
      chk(32'(r), 32'(lfw_pkg::RESP_SLVERR));
      axw(8'h0c, 32'h1, r);
      chk(32'(r), 32'(lfw_pkg::RESP_SLVERR));
      axw(8'h11, 32'h1, r);
      chk(32'(r), 32'(lfw_pkg::RESP_SLVERR));
      $display("test registers done");
   endtask

   task automatic t_period();
      meas(8'h85, 4'h0, 32'h100, 1'b0);
      meas(8'h85, 4'h1, 32'h200, 1'b0);
      meas(8'h86, 4'h0, 32'hc0, 1'b0);
      meas(8'h87, 4'h0, 32'h100, 1'b0);
      meas(8'h8b, 4'h0, 32'h180, 1'b0);
      chk(32'(frame_irq), 32'h0);
      meas(8'h95, 4'h0, 32'h100, 1'b1);
      wr(CTL, 32'h94);
      wr(STA, 32'h4);
      repeat (700) @(posedge aclk);
      chk(32'(frame_irq), 32'h0);
      $display("test frame timing done");
   endtask

   task automatic t_map();
      int n;
      for (int i = 0; i < 12; i++) wr(PIX + 8'(4 * i), 32'(pv(i)));
      for (int i = 0; i < 12; i++) rdc(PIX + 8'(4 * i), 32'(pv(i)));
      wr(CTL, 32'h87);
      for (int k = 0; k < 4; k++)
      begin
         n = 0;
         while (drive_level.common !== 4'(1 << k) && n < 2000)
         begin
            @(posedge aclk);
            n++;
         end
         chk(32'(drive_level.segment), {8'h0, pv(3 * k + 2), pv(3 * k + 1), pv(3 * k)});
      end
      $display("test pixel mapping done");
   endtask

   task automatic t_off();
      int n;
      int c0 = frame_cnt;
      while (frame_cnt == c0) @(posedge aclk);
      chk(32'(display_active_flag), 32'h1);
      wr(CTL, 32'h07);
      chk(32'(display_active_flag), 32'h1);
      wt(display_active_flag, 1'b0, n);
      chk(32'(n < 300), 32'h1);
      repeat (2) @(posedge aclk);
      chk(32'(display_irq), 32'h1);
      repeat (20) @(posedge aclk);
      chk(32'(display_irq), 32'h1);
      wr(STA, 32'h2);
      chk(32'(display_irq), 32'h0);
      $display("test shutdown done");
   endtask

   task automatic t_sleep();
      int n = 0;
      lfw_pkg::lfw_drive_s p;
      wr(CTL, 32'hc7);
      repeat (300) @(posedge aclk);
      sleep_req <= 1'b1;
      repeat (2) @(posedge aclk);
      p = drive_level;
      repeat (600)
      begin
         @(posedge aclk);
         if (drive_level !== p) n++;
      end
      chk(32'(n), 32'h0);
      // System source must halt with sleep select clear; assertion watches counters
      wr(CTL, 32'h83);
      repeat (600) @(posedge aclk);
      sleep_req <= 1'b0;
      $display("test sleep done");
   endtask

   // Pixel data is only written right after a frame interrupt
   task automatic t_typeb();
      int n;
      int t0;
      wr(PSC, 32'hf);
      wr(CTL, 32'h97);
      wr(STA, 32'h4);
      wt(frame_irq, 1'b1, n);
      wr(STA, 32'h4);
      wt(frame_irq, 1'b1, n);
      t0 = cyc;
      wr(PIX, 32'ha5);
      rdc(PIX, 32'ha5);
      rdc(CTL, 32'h97);
      wr(STA, 32'h4);
      chk(32'(frame_irq), 32'h0);
      while (cyc < t0 + 2100) @(posedge aclk);
      wr(PIX, 32'h5a);
      rdc(PIX, 32'ha5);
      rdc(CTL, 32'hb7);
      wr(CTL, 32'h97);
      rdc(CTL, 32'h97);
      wt(frame_irq, 1'b1, n);
      chk(32'(cyc - t0), 32'h2000);
      $display("test type b interrupts done");
   endtask

   // Main sequence
   initial
   begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reg();
      t_period();
      t_map();
      t_off();
      t_sleep();
      t_typeb();
      print_verdict();
   end
endmodule // lfw_driver_tb
